/* File: hw/prf_defines.svh */
// register map, field positions and timing counts of the ramp profile generator
`ifndef PRF_DEFINES_SVH
`define PRF_DEFINES_SVH

`define PRF_ADDR_W 8
`define PRF_OFS_MODE 8'h00
`define PRF_OFS_UP 8'h04
`define PRF_OFS_DOWN 8'h08
`define PRF_OFS_SV 8'h0c
`define PRF_OFS_DV 8'h10
`define PRF_OFS_TP 8'h14
`define PRF_OFS_MP 8'h18
`define PRF_OFS_CMD 8'h1c
`define PRF_OFS_STAT 8'h20
`define PRF_OFS_SPEED 8'h24
`define PRF_OFS_COUNT 8'h28

`define PRF_MODE_MASK 32'h0000_2007
`define PRF_MODE_RST 32'h0000_0000
`define PRF_BIT_MANUAL 0
`define PRF_BIT_SEPDOWN 1
`define PRF_BIT_SCURVE 2
`define PRF_BIT_TRIDIS 13

`define PRF_CMD_FIXED 0
`define PRF_CMD_CONT 1
`define PRF_CMD_STOP 2
`define PRF_CMD_DIR 3

`define PRF_RESP_OKAY 2'h0
`define PRF_RESP_SLVERR 2'h2

`define PRF_CLK_NS 10
`define PRF_CLK_HZ 34'h0_05f5_e100
`define PRF_TICK_NS 1000
`define PRF_TICK_DIV (`PRF_TICK_NS / `PRF_CLK_NS)
`define PRF_TICK_HZ 33'h0_000f_4240

`endif

/* File: hw/prf_pkg.sv */
// types of the ramp profile generator
package prf_pkg;

  typedef enum logic [1:0] {
    PRF_IDLE,
    PRF_ACC,
    PRF_CONST,
    PRF_DEC
  } prf_phase_e;

  typedef struct packed {
    logic [6:0] cnt;
    logic tick;
  } prf_tick_s;

  typedef struct packed {
    logic [32:0] acc;
    logic pulse;
  } prf_pgen_s;

  typedef struct packed {
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] mode;
    logic [31:0] up;
    logic [31:0] down;
    logic [31:0] sv;
    logic [31:0] dv;
    logic [31:0] tp;
    logic [31:0] mp;
    logic dir;
    logic fixed;
    logic stopping;
    prf_phase_e phase;
    logic [31:0] speed;
    logic [31:0] frac;
    logic [31:0] tally;
    logic [31:0] pulses;
  } prf_main_s;

endpackage

/* File: hw/prf_tick_div.sv */
// profile tick divider: one-cycle enable every tick period
`timescale 1ns/100ps
`include "prf_defines.svh"

module prf_tick_div (
  input wire logic clk_sys,
  input wire logic rst,
  output logic tick_o
);
  prf_pkg::prf_tick_s q, d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == 7'(`PRF_TICK_DIV - 1)) begin
      d.cnt = 7'h00;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 7'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_o = q.tick;
endmodule

/* File: hw/prf_pulse_gen.sv */
// drive pulse generator: phase accumulator at the current speed in pps
`timescale 1ns/100ps
`include "prf_defines.svh"

module prf_pulse_gen (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run_i,
  input wire logic [31:0] speed_i,
  output logic pulse_o
);
  prf_pkg::prf_pgen_s q, d;
  logic [33:0] sum;

  always_comb begin
    d = q;
    d.pulse = 1'b0;
    sum = {1'b0, q.acc} + {2'h0, speed_i};
    if (!run_i) begin
      d.acc = 33'h0;
    end else if (sum >= `PRF_CLK_HZ) begin
      d.acc = 33'(sum - `PRF_CLK_HZ);
      d.pulse = 1'b1;
    end else begin
      d.acc = sum[32:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pulse_o = q.pulse;
endmodule

/* File: hw/prf_ramp_gen.sv */
// linear ramp profile generator with axi4-lite registers
// Summary of operation
// - speed rises linearly from start speed to target speed at ramp-up slope
// - symmetric fixed drive tallies ramp-up pulses, decelerates when remainder drops below tally
// - symmetric deceleration uses ramp-up slope down to start speed, ends at last pulse
// - decelerating stop during ramp-up starts deceleration at once from current speed
// - manual select bit 0 clear means decel point is computed automatically
// - separate ramp-down bit 1 clear reuses ramp-up slope for deceleration
// - separate ramp-down bit 1 set uses ramp-down slope for deceleration
// - curve shape bit 2 clear gives linear ramps, not s-curves
// - triangle prevention holds speed once ramp pulses exceed half the total
// - triangle prevention active after reset, disabled by writing 1 to mode bit 13
// - decelerating stop during ramp-up skips triangle prevention
// - non-symmetric fixed drive computes decel point from remaining pulses, current speed and ramp-down slope
// - with ramp-up steeper than ramp-down, remaining creep pulses run at start speed
`timescale 1ns/100ps
`include "prf_defines.svh"

module prf_ramp_gen (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic drive_pulse,
  output logic drive_dir,
  output logic drive_busy
);
  prf_pkg::prf_main_s q, d;
  logic tick;
  logic pulse;
  logic run;
  logic run_next;
  logic wr_go;
  logic rd_go;
  logic [31:0] rem;
  logic [63:0] v_sq;
  logic [63:0] sv_sq;
  logic [63:0] rem_dn;
  logic [64:0] need_lhs;
  logic [64:0] need_rhs;
  logic auto_dec;
  logic tri_hold;
  logic [31:0] slope;
  logic [32:0] fsum;
  logic step;
  logic [32:0] fleft;
  logic last_pulse;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  prf_tick_div u_tick (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick_o(tick)
  );

  assign run = (q.phase != prf_pkg::PRF_IDLE);
  // accumulator stops on the edge that ends the drive, so no pulse trails busy
  assign run_next = (d.phase != prf_pkg::PRF_IDLE);

  prf_pulse_gen u_pgen (
    .clk_sys(clk_sys),
    .rst(rst),
    .run_i(run_next),
    .speed_i(q.speed),
    .pulse_o(pulse)
  );

  // write address and data are taken together, one write at a time
  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~q.bvalid;
  assign s_axi_wready = s_axi_awready;
  assign s_axi_arready = ~q.rvalid;
  assign wr_go = s_axi_awready;
  assign rd_go = s_axi_arvalid & ~q.rvalid;

  always_comb begin
    rem = q.tp - q.pulses;
    v_sq = {32'h0, q.speed} * {32'h0, q.speed};
    sv_sq = {32'h0, q.sv} * {32'h0, q.sv};
    // pulses still needed to ramp down: (v^2 - sv^2) / (2 * down)
    rem_dn = {32'h0, rem} * {32'h0, q.down};
    need_lhs = {rem_dn, 1'b0};
    need_rhs = (q.speed > q.sv) ? {1'b0, v_sq - sv_sq} : 65'h0;
    if (q.mode[`PRF_BIT_MANUAL]) begin
      auto_dec = (rem <= q.mp);
    end else if (!q.mode[`PRF_BIT_SEPDOWN]) begin
      auto_dec = (rem < q.tally);
    end else begin
      auto_dec = (need_lhs <= need_rhs);
    end
    // ramp-up plus the matching ramp-down passing half the total
    tri_hold = !q.mode[`PRF_BIT_TRIDIS] && q.fixed && !q.stopping
      && ({q.tally, 2'b00} > {2'b00, q.tp});
    if (q.phase == prf_pkg::PRF_DEC && q.mode[`PRF_BIT_SEPDOWN]) begin
      slope = q.down;
    end else begin
      slope = q.up;
    end
    // curve shape bit is not consulted: ramps are always linear
    fsum = {1'b0, q.frac} + {1'b0, slope};
    step = (fsum >= `PRF_TICK_HZ);
    fleft = fsum - `PRF_TICK_HZ;
    last_pulse = q.fixed && pulse && (q.pulses + 32'h1 >= q.tp);
  end

  always_comb begin
    d = q;
    // register bus
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (wr_go) begin
      d.bvalid = 1'b1;
      d.bresp = `PRF_RESP_OKAY;
      unique case (s_axi_awaddr)
        `PRF_OFS_MODE: d.mode = merge(q.mode, s_axi_wdata, s_axi_wstrb) & `PRF_MODE_MASK;
        `PRF_OFS_UP: d.up = merge(q.up, s_axi_wdata, s_axi_wstrb);
        `PRF_OFS_DOWN: d.down = merge(q.down, s_axi_wdata, s_axi_wstrb);
        `PRF_OFS_SV: d.sv = merge(q.sv, s_axi_wdata, s_axi_wstrb);
        `PRF_OFS_DV: d.dv = merge(q.dv, s_axi_wdata, s_axi_wstrb);
        `PRF_OFS_TP: d.tp = merge(q.tp, s_axi_wdata, s_axi_wstrb);
        `PRF_OFS_MP: d.mp = merge(q.mp, s_axi_wdata, s_axi_wstrb);
        `PRF_OFS_CMD: begin
          if (s_axi_wstrb[0]) begin
            if (q.phase == prf_pkg::PRF_IDLE) begin
              if (s_axi_wdata[`PRF_CMD_FIXED] && q.tp != 32'h0) begin
                d.phase = prf_pkg::PRF_ACC;
                d.fixed = 1'b1;
              end else if (s_axi_wdata[`PRF_CMD_CONT]) begin
                d.phase = prf_pkg::PRF_ACC;
                d.fixed = 1'b0;
              end
              if (d.phase == prf_pkg::PRF_ACC) begin
                d.dir = s_axi_wdata[`PRF_CMD_DIR];
                d.speed = q.sv;
                d.frac = 32'h0;
                d.tally = 32'h0;
                d.pulses = 32'h0;
                d.stopping = 1'b0;
              end
            end else if (s_axi_wdata[`PRF_CMD_STOP] && q.phase != prf_pkg::PRF_DEC) begin
              d.phase = prf_pkg::PRF_DEC;
              d.stopping = 1'b1;
              d.frac = 32'h0;
            end
          end
        end
        `PRF_OFS_STAT, `PRF_OFS_SPEED, `PRF_OFS_COUNT: ;
        default: d.bresp = `PRF_RESP_SLVERR;
      endcase
    end
    if (rd_go) begin
      d.rvalid = 1'b1;
      d.rresp = `PRF_RESP_OKAY;
      unique case (s_axi_araddr)
        `PRF_OFS_MODE: d.rdata = q.mode;
        `PRF_OFS_UP: d.rdata = q.up;
        `PRF_OFS_DOWN: d.rdata = q.down;
        `PRF_OFS_SV: d.rdata = q.sv;
        `PRF_OFS_DV: d.rdata = q.dv;
        `PRF_OFS_TP: d.rdata = q.tp;
        `PRF_OFS_MP: d.rdata = q.mp;
        `PRF_OFS_CMD: d.rdata = 32'h0;
        `PRF_OFS_STAT: d.rdata = {27'h0, q.dir, q.stopping, q.phase, run};
        `PRF_OFS_SPEED: d.rdata = q.speed;
        `PRF_OFS_COUNT: d.rdata = q.pulses;
        default: begin
          d.rdata = 32'h0;
          d.rresp = `PRF_RESP_SLVERR;
        end
      endcase
    end

    // profile engine; a pending stop command above takes precedence this cycle unless the last pulse ends the drive
    if (run && d.phase == q.phase) begin
      if (pulse) begin
        d.pulses = q.pulses + 32'h1;
        if (q.phase == prf_pkg::PRF_ACC) begin
          d.tally = q.tally + 32'h1;
        end
      end
      unique case (q.phase)
        prf_pkg::PRF_ACC: begin
          if (q.fixed && !q.stopping && auto_dec) begin
            d.phase = prf_pkg::PRF_DEC;
            d.frac = 32'h0;
          end else if (tri_hold) begin
            d.phase = prf_pkg::PRF_CONST;
          end else if (q.speed >= q.dv) begin
            d.speed = q.dv;
            d.phase = prf_pkg::PRF_CONST;
          end else if (tick) begin
            d.frac = step ? ((fleft >= `PRF_TICK_HZ) ? 32'(`PRF_TICK_HZ - 33'h1) : fleft[31:0]) : fsum[31:0];
            if (step) begin
              d.speed = q.speed + 32'h1;
            end
          end
        end
        prf_pkg::PRF_CONST: begin
          if (q.fixed && auto_dec) begin
            d.phase = prf_pkg::PRF_DEC;
            d.frac = 32'h0;
          end
        end
        prf_pkg::PRF_DEC: begin
          if (q.speed <= q.sv) begin
            d.speed = q.sv;
            if (q.stopping || !q.fixed) begin
              d.phase = prf_pkg::PRF_IDLE;
            end
          end else if (tick) begin
            d.frac = step ? ((fleft >= `PRF_TICK_HZ) ? 32'(`PRF_TICK_HZ - 33'h1) : fleft[31:0]) : fsum[31:0];
            if (step) begin
              d.speed = q.speed - 32'h1;
            end
          end
        end
        prf_pkg::PRF_IDLE: ;
      endcase
      // creep at start speed continues until every pulse is out
      if (last_pulse) begin
        d.phase = prf_pkg::PRF_IDLE;
      end
    end else if (run && last_pulse) begin
      d.pulses = q.pulses + 32'h1;
      d.phase = prf_pkg::PRF_IDLE;
    end else if (run && pulse) begin
      d.pulses = q.pulses + 32'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.mode <= `PRF_MODE_RST;
    end else begin
      q <= d;
    end
  end

  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;
  assign drive_pulse = pulse;
  assign drive_dir = q.dir;
  assign drive_busy = run;
endmodule

/* File: tb/prf_ramp_gen_monitor.sv */
// port-level assertion checker of the ramp profile generator
`timescale 1ns/100ps
`include "prf_defines.svh"
module prf_ramp_gen_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic drive_pulse,
  input wire logic drive_dir,
  input wire logic drive_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write not answered");
  AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_AR_READY: assert property (s_axi_arready != s_axi_rvalid)
    else $error("read ready wrong");
  AST_START: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !drive_busy &&
    s_axi_awaddr == `PRF_OFS_CMD && s_axi_wstrb[0] && s_axi_wdata[`PRF_CMD_CONT] |=> drive_busy)
    else $error("start not taken");
  AST_PULSE_ONE: assert property (drive_pulse |=> !drive_pulse)
    else $error("pulse too long");
  AST_PULSE_BUSY: assert property (drive_pulse |-> drive_busy)
    else $error("pulse while idle");
  AST_DIR_HOLD: assert property (drive_busy && $past(drive_busy) |-> $stable(drive_dir))
    else $error("direction moved");
endmodule
bind prf_ramp_gen prf_ramp_gen_monitor prf_ramp_gen_monitor_inst (.clk_sys(clk_sys), .rst(rst),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .drive_pulse(drive_pulse), .drive_dir(drive_dir), .drive_busy(drive_busy));

/* File: tb/prf_motor_model.sv */
// motor driver model: counts drive pulses and keeps the direction seen
`timescale 1ns/100ps
module prf_motor_model (
  input wire logic clk_sys,
  input wire logic clr,
  input wire logic step,
  input wire logic dir,
  output int steps,
  output logic dir_seen
);
  always @(posedge clk_sys) begin
    if (clr) begin
      steps <= 0;
    end else if (step) begin
      steps <= steps + 1;
      dir_seen <= dir;
    end
  end
endmodule

/* File: tb/prf_ramp_gen_tb_top.sv */
// self-checking bench of the ramp profile generator
`timescale 1ns/100ps
`include "prf_defines.svh"
module prf_ramp_gen_tb_top;
  localparam logic [31:0] SV = 32'h001e_8480;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic clr = 1'b1;
  logic [7:0] aw = 8'h0, ar = 8'h0;
  logic [31:0] wd = 32'h0, rdata, r, s, t, pk;
  logic awv = 1'b0, wv = 1'b0, arv = 1'b0, bb = 1'b0, rr = 1'b0;
  logic awr, wr_rdy, bv, arr, rv, pulse, dir, busy, mdir;
  logic [1:0] bresp, rresp, rs, bs;
  logic [31:0] seed = 32'h0001_67fa;
  int steps, n;
  int mismatches = 0;
  int tests_run = 0;
  always #(`PRF_CLK_NS / 2) clk_sys = ~clk_sys;
  prf_ramp_gen prf_ramp_gen_inst (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bb), .s_axi_araddr(ar), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .drive_pulse(pulse), .drive_dir(dir), .drive_busy(busy));
  prf_motor_model prf_motor_model_inst (.clk_sys(clk_sys), .clr(clr), .step(pulse), .dir(dir),
    .steps(steps), .dir_seen(mdir));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // peak speed bound for a drive of t pulses, sh selects the profile
  function automatic logic [31:0] top(input logic [31:0] tp, input int sh);
    return SV + (tp >> sh);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // response ready is raised after a random pause so held answers are exercised
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do @(posedge clk_sys); while (awr !== 1'b1 || wr_rdy !== 1'b1);
    awv <= 1'b0;
    wv <= 1'b0;
    repeat (rnd() & 32'h3) @(posedge clk_sys);
    bb <= 1'b1;
    do @(posedge clk_sys); while (bv !== 1'b1);
    bs = bresp;
    bb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    ar <= a;
    arv <= 1'b1;
    do @(posedge clk_sys); while (arr !== 1'b1);
    arv <= 1'b0;
    repeat (rnd() & 32'h3) @(posedge clk_sys);
    rr <= 1'b1;
    do @(posedge clk_sys); while (rv !== 1'b1);
    r = rdata;
    rs = rresp;
    rr <= 1'b0;
  endtask
  task automatic setup(input logic [31:0] md, input logic [31:0] dv, input logic [31:0] tp);
    wr(`PRF_OFS_MODE, md);
    wr(`PRF_OFS_UP, 32'h000f_4240);
    wr(`PRF_OFS_DOWN, 32'h0007_a120);
    wr(`PRF_OFS_SV, SV);
    wr(`PRF_OFS_DV, dv);
    wr(`PRF_OFS_TP, tp);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
  endtask
  // issues a command, then tracks the peak speed until the drive ends
  task automatic run(input logic [31:0] cmd);
    int i;
    pk = 32'h0;
    wr(`PRF_OFS_CMD, cmd);
    for (i = 0; i < 9000 && busy !== 1'b0; i++) begin
      rd(`PRF_OFS_SPEED);
      if (r > pk) pk = r;
    end
    chk({31'h0, busy}, 32'h0, "end");
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge clk_sys);
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`PRF_OFS_MODE);
    chk(r, 32'h0, "mode rst");
    wr(`PRF_OFS_MODE, 32'hffff_ffff);
    chk({30'h0, bs}, 32'h0, "wr okay");
    rd(`PRF_OFS_MODE);
    chk(r, 32'h0000_2007, "mode");
    rd(8'h2c);
    chk({30'h0, rs}, 32'h2, "unmapped");
    wr(8'h2c, 32'h0);
    chk({30'h0, bs}, 32'h2, "unmapped wr");
    $display("registers done");
    setup(32'h0, SV + 32'h14, 32'h0);
    wr(`PRF_OFS_CMD, 32'h2);
    pk = SV;
    for (n = 0; n < 5000 && pk !== SV + 32'h14; n++) begin
      rd(`PRF_OFS_SPEED);
      if ((r >= pk && r <= SV + 32'h14) !== 1'b1) chk(r, pk, "ramp");
      pk = r;
    end
    chk(pk, SV + 32'h14, "target");
    run(32'h4);
    chk({31'h0, pk <= SV + 32'h14}, 32'h1, "decel");
    setup(32'h0, SV + 32'h28, 32'h7d0);
    wr(`PRF_OFS_CMD, 32'h1);
    repeat (1000) @(posedge clk_sys);
    rd(`PRF_OFS_SPEED);
    s = r;
    run(32'h4);
    chk({31'h0, pk <= s + 32'h1 && s < SV + 32'h28}, 32'h1, "stop");
    chk({31'h0, steps < 2000}, 32'h1, "stop early");
    $display("ramp and stop done");
    t = 32'h40 + (rnd() & 32'h3f);
    s = rnd() & 32'h8;
    setup(32'h0, SV + 32'h3e8, t);
    run(32'h1 | s);
    chk(32'(steps), t, "total");
    chk({31'h0, mdir}, {31'h0, s[3]}, "dir");
    chk({31'h0, pk <= top(t, 3) + 32'h2}, 32'h1, "hold");
    setup(32'h2000, SV + 32'h3e8, t);
    run(32'h1);
    chk(32'(steps), t, "total");
    chk({31'h0, pk + 32'h2 >= top(t, 2)}, 32'h1, "no hold");
    setup(32'h2002, SV + 32'h3e8, t);
    run(32'h1);
    chk(32'(steps), t, "total");
    chk({31'h0, pk <= SV + t / 32'h5 + 32'h1}, 32'h1, "slow decel");
    // manual point: decelerate once 16 pulses are out, so the peak stays low
    setup(32'h2001, SV + 32'h3e8, t);
    wr(`PRF_OFS_MP, t - 32'h10);
    run(32'h1);
    chk(32'(steps), t, "total");
    chk({31'h0, pk <= SV + 32'ha}, 32'h1, "manual point");
    $display("fixed drives done");
    end_sim();
  end
endmodule
